// ---- bench/bsl_mem_model.sv ----
// Purpose: behavioural serial boot memory answering the loader's read
// Assumes: mode 0 link, memory changes its data line on the falling clock
// Notes:   the image is filled by the bench before reset is released
`timescale 1ns/10ps
`default_nettype none

module bsl_mem_model #(
    parameter int N = 8
) (
    // link seen from the memory side
    input  wire logic sel_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0]  image [N];
    logic [23:0] hdr;
    int          bits;
    int          rises;

    // idle state before the first transaction
    initial begin
        miso  = 1'b0;
        hdr   = '0;
        bits  = 0;
        rises = 0;
    end

    // a falling select opens a fresh transaction
    always @(negedge sel_n) begin
        bits = 0;
        hdr  = '0;
    end

    // command and address taken msb first on each rising clock
    always @(posedge sck) begin
        if (!sel_n) begin
            if (bits < 24) hdr = {hdr[22:0], mosi};
            bits++;
            rises++;
        end
    end

    // image bits leave on the falling clock, byte after byte, msb first
    always @(negedge sck) begin
        if (!sel_n && bits >= 24) begin
            miso = image[((bits - 24) / 8) % N][7 - (bits - 24) % 8];
        end
    end

    // a released line never keeps showing the last bit
    always @(posedge sel_n) miso = ~miso;

endmodule : bsl_mem_model

`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the boot image serial loader
// Assumes: 40 MHz clock, short image of 8 bytes
// Notes:   a queue of expected words is built from the memory's image
`timescale 1ns/10ps
`default_nettype none
`include "bsl_regs.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); end end

module testbench
    import bsl_pkg::*;
;
    localparam int N = 8;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              sel_n, sck_o, sck_oe_n, d2_o, d2_oe_n, mosi_o, mosi_oe_n;
    logic              miso, pad1, pad2, pad3, cpu_reset_n, boot_done;
    logic [2:0]        gpio_f_out = '0;
    logic [2:0]        gpio_f_oe_n = '0;
    logic [2:0]        gpio_f_in;
    logic [2:0]        ext = '0;
    logic [12:0]       program_counter = '0;
    logic [15:0]       prog_instr;
    logic [15:0]       exp_q [$];
    logic              prev_sck = 1'b0;
    int                run = 0;
    int                fails = 0;
    int                n_checks = 0;

    // clock
    always #12.5 clock = ~clock;

    // wire levels from every party's enable
    assign pad1 = sck_oe_n ? ext[0] : sck_o;
    assign pad2 = d2_oe_n ? (boot_done ? ext[1] : miso) : d2_o;
    assign pad3 = mosi_oe_n ? ext[2] : mosi_o;

    bsl_loader #(.IMAGE_BYTES(N)) u_dut (
        .clock(clock), .rst_n(rst_n), .boot_mem_select_n(sel_n),
        .port_f_bit1_clock_pin_i(pad1), .port_f_bit1_clock_pin_o(sck_o),
        .port_f_bit1_clock_pin_oe_n(sck_oe_n),
        .port_f_bit2_in_pin_i(pad2), .port_f_bit2_in_pin_o(d2_o),
        .port_f_bit2_in_pin_oe_n(d2_oe_n),
        .port_f_bit3_out_pin_i(pad3), .port_f_bit3_out_pin_o(mosi_o),
        .port_f_bit3_out_pin_oe_n(mosi_oe_n),
        .gpio_f_out(gpio_f_out), .gpio_f_oe_n(gpio_f_oe_n), .gpio_f_in(gpio_f_in),
        .cpu_reset_n(cpu_reset_n), .boot_done(boot_done),
        .program_counter(program_counter), .prog_instr(prog_instr)
    );

    bsl_mem_model #(.N(N)) u_mem (
        .sel_n(sel_n), .sck(pad1), .mosi(pad3), .miso(miso)
    );

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // per-cycle checks of pins and phases, then fresh random pin stimulus
    always @(negedge clock) begin
        if (rst_n) begin
            if (!boot_done) begin
                `CHK(gpio_f_in, 3'h0)
                `CHK({mosi_oe_n, d2_oe_n, sck_oe_n}, 3'h2)
                `CHK(cpu_reset_n, 1'b0)
                if (!sel_n) begin
                    if (sck_o !== prev_sck) begin
                        `CHK(run, `BSL_HALF_CYC)
                        run = 1;
                    end else begin
                        run++;
                    end
                end else begin
                    run = 0;
                end
                prev_sck = sck_o;
                program_counter = 13'($urandom);
            end else begin
                `CHK(sel_n, 1'b1)
                `CHK(cpu_reset_n, 1'b1)
                `CHK({mosi_oe_n, d2_oe_n, sck_oe_n}, gpio_f_oe_n)
                `CHK({mosi_o, d2_o, sck_o}, gpio_f_out)
                `CHK(gpio_f_in, {pad3, pad2, pad1})
            end
            gpio_f_out  = 3'($urandom);
            gpio_f_oe_n = 3'($urandom);
            ext         = 3'($urandom);
        end
    end

    // watchdog, far beyond one short download and the read-back
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end

    // main sequence
    initial begin
        void'($urandom(32'h5FE2));
        for (int i = 0; i < N; i++) u_mem.image[i] = 8'($urandom);
        for (int i = 0; i < N; i += 2) exp_q.push_back({u_mem.image[i+1], u_mem.image[i]});
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 5000 && boot_done !== 1'b1; i++) @(negedge clock);
        `CHK(boot_done, 1'b1)
        `CHK(u_mem.hdr, {`BSL_READ_OP, `BSL_START_ADDR})
        `CHK(u_mem.rises, 24 + 8 * N)
        // read back the image through the fetch port
        for (int k = 0; k < exp_q.size(); k++) begin
            @(negedge clock);
            program_counter = 13'(k);
            @(negedge clock);
            `CHK(prog_instr, exp_q[k])
        end
        repeat (300) @(negedge clock);
        `CHK(u_mem.rises, 24 + 8 * N)
        // the first word must survive the long stretch of random pin traffic
        program_counter = 13'h0000;
        @(negedge clock);
        `CHK(prog_instr, exp_q[0])
        stop_test();
    end

endmodule : testbench

`default_nettype wire

// ---- core/bsl_loader.sv ----
// Purpose: power-on download of the program image from a serial boot memory
// Assumes: one 40 MHz clock; pin inputs synchronous to it
// Notes:   the serial clock is stretched only if the byte buffer is full
// Function
// - select goes low and the serial clock runs until the read ends
// - read command 0x03 is shifted out first
// - a 16-bit start address of zero follows the command
// - only two address bytes are sent, never three
// - after 16K image bytes the clock stops and select goes high
// - everything moves most significant bit first, opened by select falling
// - select stays low through the download and high forever after
// - the three link pins return to general I/O control when done
// - firmware has no access at all to the loader link
// - only the download writes the program memory
// - program memory is 8K words of 16 bits, 13-bit program counter
// - link pins: first clock out, second data in, third data out
// - serial clock is derived from the system clock by a divider
`timescale 1ns/10ps
`default_nettype none
`include "bsl_regs.svh"

module bsl_loader
    import bsl_pkg::*;
#(
    parameter int IMAGE_BYTES = `BSL_IMAGE_BYTES
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // serial memory select pin, active low
    output logic                        boot_mem_select_n,
    // port f bit 1: serial clock during download
    input  wire logic                   port_f_bit1_clock_pin_i,
    output logic                        port_f_bit1_clock_pin_o,
    output logic                        port_f_bit1_clock_pin_oe_n,
    // port f bit 2: serial data from memory during download
    input  wire logic                   port_f_bit2_in_pin_i,
    output logic                        port_f_bit2_in_pin_o,
    output logic                        port_f_bit2_in_pin_oe_n,
    // port f bit 3: serial data to memory during download
    input  wire logic                   port_f_bit3_out_pin_i,
    output logic                        port_f_bit3_out_pin_o,
    output logic                        port_f_bit3_out_pin_oe_n,
    // general I/O control of port f bits 3..1 (index 0 is bit 1)
    input  wire logic [2:0]             gpio_f_out,
    input  wire logic [2:0]             gpio_f_oe_n,
    output logic [2:0]                  gpio_f_in,
    // processor side
    output logic                        cpu_reset_n,
    output logic                        boot_done,
    input  wire logic [`BSL_PC_W-1:0]   program_counter,
    output logic [`BSL_WORD_W-1:0]      prog_instr
);
    localparam logic [3:0]  HALF_LAST = 4'(`BSL_HALF_CYC - 1);
    localparam logic [15:0] HDR_BYTES = 16'(`BSL_HDR_BYTES);
    localparam logic [15:0] TOTAL     = 16'(IMAGE_BYTES + `BSL_HDR_BYTES);
    localparam logic [`BSL_HDR_BITS-1:0] HEADER = {`BSL_READ_OP, `BSL_START_ADDR};

    bsl_top_s q;
    bsl_top_s n;

    logic                   tick;
    logic                   miso;
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic [`BSL_BYTE_W-1:0] buf_out_data;
    logic [`BSL_BYTE_W-1:0] rx_byte;
    logic                   loading;

    // header bit expected at a given header position, msb first
    function automatic logic hdr_bit(input logic [15:0] byte_i, input logic [2:0] bit_i);
        logic [4:0] pos;
        pos     = 5'({byte_i[1:0], bit_i});
        hdr_bit = HEADER[`BSL_HDR_TOP - pos];
    endfunction : hdr_bit

    assign tick    = (q.hc == HALF_LAST);
    assign miso    = port_f_bit2_in_pin_i;
    assign rx_byte = {q.rx[`BSL_BYTE_W-2:0], miso};
    assign loading = (q.st != ST_DONE);

    // sequencer, serial shifter and word packer
    always_comb begin
        n    = q;
        n.we = 1'b0;
        if (q.we) begin
            n.waddr = `BSL_PC_W'(q.waddr + 1'b1);
        end
        if (q.pend && buf_in_ready) begin
            n.pend = 1'b0;
        end
        unique case (q.st)
            ST_BOOT: begin
                n.st    = ST_SHIFT;
                n.sel_n = 1'b0;
                n.tx    = HEADER;
                n.hc    = '0;
            end
            ST_SHIFT: begin
                if (!tick) begin
                    n.hc = 4'(q.hc + 1'b1);
                end else if (!q.sck) begin
                    // rising edge: sample, unless the last byte still waits for room
                    if (!q.pend) begin
                        n.hc    = '0;
                        n.sck   = 1'b1;
                        n.rx    = rx_byte;
                        n.bit_i = 3'(q.bit_i + 1'b1);
                        if (q.bit_i == `BSL_BIT_LAST) begin
                            n.byte_i = 16'(q.byte_i + 1'b1);
                            if (q.byte_i >= HDR_BYTES) begin
                                n.pend      = 1'b1;
                                n.pend_byte = rx_byte;
                            end
                        end
                    end
                end else begin
                    // falling edge: present the next outgoing bit
                    n.hc  = '0;
                    n.sck = 1'b0;
                    n.tx  = {q.tx[`BSL_HDR_BITS-2:0], 1'b0};
                    if (q.byte_i == TOTAL) begin
                        n.st = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                // hold select low for one half period after the last edge
                if (!tick) begin
                    n.hc = 4'(q.hc + 1'b1);
                end else begin
                    n.hc    = '0;
                    n.sel_n = 1'b1;
                    n.st    = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (!q.pend && !buf_out_valid && !q.we && !q.have_low) begin
                    n.st   = ST_DONE;
                    n.done = 1'b1;
                end
            end
            ST_DONE: begin
                n.sel_n = 1'b1;
            end
            default: begin
                n.st = ST_BOOT;
            end
        endcase
        // packer drains the buffer every cycle
        if (buf_out_valid) begin
            if (!q.have_low) begin
                n.have_low = 1'b1;
                n.low      = buf_out_data;
            end else begin
                n.have_low = 1'b0;
                n.we       = loading;
                n.wdata    = {buf_out_data, q.low};
            end
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q       <= '0;
            q.st    <= ST_BOOT;
            q.sel_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // byte buffer between shifter and packer
    bsl_pair_buf #(
        .WIDTH (`BSL_BYTE_W),
        .DEPTH (2)
    ) u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (q.pend),
        .in_data   (q.pend_byte),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (1'b1)
    );

    // program memory, written only by the packer
    bsl_prog_mem u_mem (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (q.we),
        .wr_addr (q.waddr),
        .wr_data (q.wdata),
        .rd_addr (program_counter),
        .rd_data (prog_instr)
    );

    // pin sharing: link during download, general I/O afterwards
    assign boot_mem_select_n          = q.sel_n;
    assign port_f_bit1_clock_pin_o    = loading ? q.sck : gpio_f_out[0];
    assign port_f_bit1_clock_pin_oe_n = loading ? 1'b0 : gpio_f_oe_n[0];
    assign port_f_bit2_in_pin_o       = loading ? 1'b0 : gpio_f_out[1];
    assign port_f_bit2_in_pin_oe_n    = loading ? 1'b1 : gpio_f_oe_n[1];
    assign port_f_bit3_out_pin_o      = loading ? q.tx[`BSL_HDR_BITS-1] : gpio_f_out[2];
    assign port_f_bit3_out_pin_oe_n   = loading ? 1'b0 : gpio_f_oe_n[2];
    // firmware sees the pins only once the link is released
    assign gpio_f_in = loading ? 3'h0 :
                       {port_f_bit3_out_pin_i, port_f_bit2_in_pin_i, port_f_bit1_clock_pin_i};
    assign cpu_reset_n = q.done;
    assign boot_done   = q.done;

    // assertions
    sequence s_high_half;
        port_f_bit1_clock_pin_o [*7] ##1 !port_f_bit1_clock_pin_o;
    endsequence

    sequence s_open_low;
        !port_f_bit1_clock_pin_o [*7];
    endsequence

    property p_sck_high_half;
        @(posedge clock) disable iff (!rst_n)
        loading && $rose(port_f_bit1_clock_pin_o) |-> s_high_half;
    endproperty
    a_sck_high_half: assert property (p_sck_high_half)
        else $error("clock high phase wrong");

    property p_select_opens;
        @(posedge clock) disable iff (!rst_n)
        $fell(boot_mem_select_n) |-> s_open_low;
    endproperty
    a_select_opens: assert property (p_select_opens)
        else $error("clock moved at select fall");

    property p_sel_low_shift;
        @(posedge clock) disable iff (!rst_n)
        (q.st == ST_SHIFT) |-> !boot_mem_select_n && !port_f_bit1_clock_pin_oe_n;
    endproperty
    a_sel_low_shift: assert property (p_sel_low_shift)
        else $error("select high in download");

    property p_header_bits;
        @(posedge clock) disable iff (!rst_n)
        (q.st == ST_SHIFT) && tick && !q.sck && !q.pend && (q.byte_i < HDR_BYTES)
            |-> port_f_bit3_out_pin_o == hdr_bit(q.byte_i, q.bit_i);
    endproperty
    a_header_bits: assert property (p_header_bits)
        else $error("wrong command or address bit");

    property p_stop_count;
        @(posedge clock) disable iff (!rst_n)
        (q.st == ST_SHIFT) ##1 (q.st == ST_TAIL) |-> (q.byte_i == TOTAL) && !q.sck;
    endproperty
    a_stop_count: assert property (p_stop_count)
        else $error("stopped at wrong byte count");

    property p_sel_stays_high;
        @(posedge clock) disable iff (!rst_n)
        (q.st == ST_DONE) |=> boot_mem_select_n && (q.st == ST_DONE) && !q.sck;
    endproperty
    a_sel_stays_high: assert property (p_sel_stays_high)
        else $error("select fell after done");

    property p_pins_released;
        @(posedge clock) disable iff (!rst_n)
        boot_done |-> port_f_bit3_out_pin_o == gpio_f_out[2]
                   && port_f_bit1_clock_pin_oe_n == gpio_f_oe_n[0];
    endproperty
    a_pins_released: assert property (p_pins_released)
        else $error("pins not handed back");

    property p_no_late_write;
        @(posedge clock) disable iff (!rst_n)
        boot_done |-> !q.we;
    endproperty
    a_no_late_write: assert property (p_no_late_write)
        else $error("memory written after boot");

    property p_reset_held;
        @(posedge clock) disable iff (!rst_n)
        $rose(cpu_reset_n) |-> boot_mem_select_n && $past(q.st) == ST_FLUSH && !$past(q.we);
    endproperty
    a_reset_held: assert property (p_reset_held)
        else $error("processor released early");

    property p_word_pair;
        @(posedge clock) disable iff (!rst_n)
        buf_out_valid && q.have_low ##1 1'b1 |-> q.we && q.wdata[`BSL_BYTE_W-1:0] == $past(q.low);
    endproperty
    a_word_pair: assert property (p_word_pair) else $error("word halves swapped");

    // low phase of the serial clock lasts a full half period as well
    property p_sck_low_half;
        @(posedge clock) disable iff (!rst_n)
        loading && $fell(port_f_bit1_clock_pin_o) |-> s_open_low;
    endproperty
    a_sck_low_half: assert property (p_sck_low_half)
        else $error("clock low phase too short");

    // outgoing bit only moves with the falling clock
    property p_mosi_steady;
        @(posedge clock) disable iff (!rst_n)
        (q.st == ST_SHIFT) && q.sck |-> $stable(port_f_bit3_out_pin_o);
    endproperty
    a_mosi_steady: assert property (p_mosi_steady)
        else $error("data out moved while clock high");

    // data-in pin is never driven and firmware sees nothing while loading
    property p_in_pin_free;
        @(posedge clock) disable iff (!rst_n)
        loading |-> port_f_bit2_in_pin_oe_n && (gpio_f_in == 3'h0);
    endproperty
    a_in_pin_free: assert property (p_in_pin_free)
        else $error("data in pin driven in download");

endmodule : bsl_loader

`default_nettype wire

// ---- core/bsl_pair_buf.sv ----
// Purpose: small valid/ready buffer between serial receiver and word packer
// Assumes: both sides on one clock
// Notes:   full and empty are exact; in_ready drops when every entry is taken
`timescale 1ns/10ps
`default_nettype none

module bsl_pair_buf
    import bsl_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // draining side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } bsl_buf_s;

    bsl_buf_s q;
    bsl_buf_s n;
    logic     push;
    logic     pop;

    // pointer advance with wrap at the last entry
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : next_ptr

    // handshake terms
    assign in_ready  = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next state
    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp        = next_ptr(q.wp);
        end
        if (pop) begin
            n.rp = next_ptr(q.rp);
        end
        n.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    property p_no_overflow;
        @(posedge clock) disable iff (!rst_n)
        (q.cnt == CW'(DEPTH)) && !pop |=> (q.cnt == CW'(DEPTH));
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("buffer lost or gained an entry");

    // a byte pushed into an empty buffer is offered unchanged on the next cycle
    property p_pass_through;
        @(posedge clock) disable iff (!rst_n)
        push && (q.cnt == '0) |=> out_valid && (out_data == $past(in_data));
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("buffer changed a byte");

endmodule : bsl_pair_buf

`default_nettype wire

// ---- core/bsl_prog_mem.sv ----
// Purpose: program memory filled by the loader, read by the processor
// Assumes: writes come only from the loader port
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/10ps
`default_nettype none
`include "bsl_regs.svh"

module bsl_prog_mem
    import bsl_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // loader write port
    input  wire logic                   wr_en,
    input  wire logic [`BSL_PC_W-1:0]   wr_addr,
    input  wire logic [`BSL_WORD_W-1:0] wr_data,
    // processor fetch port
    input  wire logic [`BSL_PC_W-1:0]   rd_addr,
    output logic [`BSL_WORD_W-1:0]      rd_data
);
    logic [`BSL_WORD_W-1:0] mem [0:`BSL_MEM_WORDS-1];
    logic [`BSL_WORD_W-1:0] rd_r;
    logic [`BSL_WORD_W-1:0] rd_nxt;

    // array write, the only path into the words
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // fetch data
    always_comb begin
        rd_nxt = mem[rd_addr];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rd_data = rd_r;

endmodule : bsl_prog_mem

`default_nettype wire

// ---- inc/bsl_pkg.sv ----
// Purpose: types shared by the boot image serial loader
// Assumes: bsl_regs.svh supplies the numeric constants
// Notes:   the whole loader state is one packed struct
`include "bsl_regs.svh"

package bsl_pkg;

    // download sequencer states
    typedef enum logic [2:0] {
        ST_BOOT,
        ST_SHIFT,
        ST_TAIL,
        ST_FLUSH,
        ST_DONE
    } bsl_state_e;

    // complete state of the loader top
    typedef struct packed {
        bsl_state_e                  st;
        logic [3:0]                  hc;
        logic                        sck;
        logic                        sel_n;
        logic [`BSL_HDR_BITS-1:0]    tx;
        logic [`BSL_BYTE_W-1:0]      rx;
        logic [2:0]                  bit_i;
        logic [15:0]                 byte_i;
        logic                        pend;
        logic [`BSL_BYTE_W-1:0]      pend_byte;
        logic                        have_low;
        logic [`BSL_BYTE_W-1:0]      low;
        logic [`BSL_PC_W-1:0]        waddr;
        logic                        we;
        logic [`BSL_WORD_W-1:0]      wdata;
        logic                        done;
    } bsl_top_s;

endpackage : bsl_pkg

// ---- inc/bsl_regs.svh ----
// Purpose: named constants of the boot image serial loader
// Assumes: one 40 MHz clock feeds the loader
// Notes:   no software-visible registers exist; these are link and timing figures
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH

// clock rate and serial clock ceiling, in hertz
`define BSL_CLK_HZ      40000000
`define BSL_SCK_HZ      3000000
// half serial clock period in clock cycles, rounded up so the rate never exceeds the ceiling
`define BSL_HALF_CYC    ((`BSL_CLK_HZ + 2 * `BSL_SCK_HZ - 1) / (2 * `BSL_SCK_HZ))

// read command and start address sent ahead of the image
`define BSL_READ_OP     8'h03
`define BSL_START_ADDR  16'h0000
`define BSL_HDR_BITS    24
`define BSL_HDR_BYTES   3
`define BSL_HDR_TOP     5'h17

// image size and program memory shape
`define BSL_IMAGE_BYTES 16384
`define BSL_MEM_WORDS   8192
`define BSL_PC_W        13
`define BSL_WORD_W      16
`define BSL_BYTE_W      8
`define BSL_BIT_LAST    3'h7

`endif
